// file: pmdl_byte_fifo.sv
// Purpose: Synchronous byte FIFO with fill count
// Assumes: Push when full and pop when empty are dropped
// Notes: Read data is combinational from the head entry
`timescale 1ns/1ps
module pmdl_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  // Drain side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] pop_data,
  // Status
  output logic                  full,
  output logic                  empty,
  output logic      [CW-1:0]    count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             do_push;
  logic             do_pop;

  assign full     = (count_r == CW'(DEPTH));
  assign empty    = (count_r == '0);
  assign count    = count_r;
  assign pop_data = mem[rd_ptr_r];
  assign do_push  = push && !full;
  assign do_pop   = pop && !empty;

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr_r] <= push_data;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      if (do_pop)
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      // Full blocks the push, so the count never passes capacity
      if (do_push && !do_pop)
        count_r <= count_r + 1'b1;
      else if (do_pop && !do_push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule

// file: pmdl_dev_end.sv
// Purpose: Device end: data link registers, tx serializer, rx byte assembly
// Assumes: Link bits and frame events arrive synchronous to clk
// Notes: Flag, stuffing and checksum logic sit outside this module
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module pmdl_dev_end #(
  parameter int DEPTH = pmdl_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register bus
  pmdl_if.dev             bus,
  // Pending requests held outside
  input  wire logic [7:0] irq_req,
  // Transmit link
  output logic            tx_bit,
  output logic            tx_busy,
  // Receive link, destuffed
  input  wire logic       rx_bit,
  input  wire logic       rx_bit_valid,
  input  wire logic       rx_frame_end,
  input  wire logic       rx_frame_good,
  input  wire logic       rx_fcs_bad,
  // Line alarms
  input  wire logic       ds3_los,
  input  wire logic       ds3_oof,
  input  wire logic       ds3_ais,
  input  wire logic       ds3_idle,
  // Request to the counter request register
  output logic            checksum_count_saturated_req
);
  import pmdl_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

  logic [7:0]  masks_r;
  logic [7:0]  ctrl_r;
  logic [7:0]  len_r;
  logic [7:0]  cnt_hi_r;
  logic [7:0]  rdata_r;
  logic [15:0] fcs_cnt_r;
  logic        irq_r;
  logic        sat_r;
  logic [15:0] div_r;
  logic        bit_tick;
  tx_state_t   tx_state_r;
  logic [7:0]  tx_sr_r;
  logic [2:0]  tx_left_r;
  logic        tx_bit_r;
  logic [7:0]  rx_sr_r;
  logic [2:0]  rx_cnt_r;
  logic [8:0]  frm_bytes_r;
  logic        rx_en;
  logic        rx_push;
  logic [7:0]  rx_byte;
  logic        tx_pop;
  logic [7:0]  tx_head;
  logic        tx_empty;
  logic [7:0]  rx_head;
  logic [CW-1:0] rx_count;
  logic        rd_rx;
  logic        rd_len;
  logic        rd_lo;
  logic        fcs_inc;
  logic [7:0]  req_eff;

  assign rx_en   = ctrl_r[CTRL_RX_EN];
  assign rd_rx   = bus.reg_rd && (bus.reg_addr == ADDR_RX_FIFO);
  assign rd_len  = bus.reg_rd && (bus.reg_addr == ADDR_RX_LEN);
  assign rd_lo   = bus.reg_rd && (bus.reg_addr == ADDR_FCS_LO);
  assign rx_byte = {rx_bit, rx_sr_r[7:1]};
  assign rx_push = rx_en && rx_bit_valid && (rx_cnt_r == 3'h7);
  assign fcs_inc = rx_fcs_bad && rx_en && !(ds3_los || ds3_oof || ds3_ais || ds3_idle);

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs

  pmdl_byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .push      (bus.reg_wr && (bus.reg_addr == ADDR_TX_FIFO)),
    .push_data (bus.reg_wdata),
    .pop       (tx_pop),
    .pop_data  (tx_head),
    .full      (),
    .empty     (tx_empty),
    .count     ()
  );

  pmdl_byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .push      (rx_push),
    .push_data (rx_byte),
    .pop       (rd_rx),
    .pop_data  (rx_head),
    .full      (),
    .empty     (),
    .count     (rx_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      masks_r <= MASKS_RST;
    else if (bus.reg_wr && (bus.reg_addr == ADDR_MASKS))
      masks_r <= bus.reg_wdata;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_r <= CTRL_RST;
    else if (bus.reg_wr && (bus.reg_addr == ADDR_CTRL))
      ctrl_r <= bus.reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_r <= 8'h00;
    else if (bus.reg_rd)
    begin
      case (bus.reg_addr)
        ADDR_MASKS:   rdata_r <= masks_r;
        ADDR_RX_FIFO: rdata_r <= rx_head;
        ADDR_RX_LEN:  rdata_r <= len_r;
        ADDR_RX_FILL: rdata_r <= 8'(rx_count);
        ADDR_FCS_LO:  rdata_r <= fcs_cnt_r[7:0];
        ADDR_CNT_HI:  rdata_r <= cnt_hi_r;
        ADDR_CTRL:    rdata_r <= ctrl_r;
        default:      rdata_r <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin

  always_comb
  begin
    req_eff = irq_req;
    if (!rx_en)
      req_eff[7:MASK_RX_LSB] = '0;
  end

  // Registered so the pin never glitches while masks change
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_r <= 1'b0;
    else
      irq_r <= (|(masks_r & req_eff)) ^ ctrl_r[CTRL_IRQ_POL];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit serializer

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_r <= 16'h0000;
    else if (div_r == BIT_DIV - 16'h0001)
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001;
  end

  assign bit_tick = (div_r == BIT_DIV - 16'h0001);
  assign tx_pop   = bit_tick && !tx_empty && (tx_state_r == TX_IDLE || tx_left_r == 3'h0);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_state_r <= TX_IDLE;
      tx_sr_r    <= 8'h00;
      tx_left_r  <= 3'h0;
      tx_bit_r   <= 1'b1;
    end
    else if (bit_tick)
    begin
      case (tx_state_r)
        TX_SHIFT:
        begin
          if (tx_left_r != 3'h0)
          begin
            tx_bit_r  <= tx_sr_r[0];
            tx_sr_r   <= {1'b0, tx_sr_r[7:1]};
            tx_left_r <= tx_left_r - 3'h1;
          end
          else if (tx_pop)
          begin
            tx_bit_r  <= tx_head[0];
            tx_sr_r   <= {1'b0, tx_head[7:1]};
            tx_left_r <= 3'h7;
          end
          else
          begin
            tx_bit_r   <= 1'b1;
            tx_state_r <= TX_IDLE;
          end
        end
        default:
        begin
          if (tx_pop)
          begin
            tx_bit_r   <= tx_head[0];
            tx_sr_r    <= {1'b0, tx_head[7:1]};
            tx_left_r  <= 3'h7;
            tx_state_r <= TX_SHIFT;
          end
          else
            tx_bit_r <= 1'b1;
        end
      endcase
    end
  end

  assign tx_bit  = tx_bit_r;
  assign tx_busy = (tx_state_r == TX_SHIFT);

  ////////////////////////////////////////////////////////////////////////////
  // Receive byte assembly

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_sr_r  <= 8'h00;
      rx_cnt_r <= 3'h0;
    end
    else if (!rx_en || rx_frame_end)
      rx_cnt_r <= 3'h0;
    else if (rx_bit_valid)
    begin
      rx_sr_r  <= rx_byte;
      rx_cnt_r <= rx_cnt_r + 3'h1;
    end
  end

  // Byte count of the frame in progress, held at 256 once passed
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      frm_bytes_r <= 9'h000;
    else if (rx_frame_end || !rx_en)
      frm_bytes_r <= 9'h000;
    else if (rx_push && frm_bytes_r != LEN_SAT)
      frm_bytes_r <= frm_bytes_r + 9'h001;
  end

  // Load wins over the read clear so no frame length is lost
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      len_r <= 8'h00;
    else if (rx_frame_end && rx_en)
    begin
      if (rx_frame_good && (frm_bytes_r == 9'h000 || frm_bytes_r[8]))
        len_r <= 8'hff;
      else
        len_r <= frm_bytes_r[7:0];
    end
    else if (rd_len)
      len_r <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checksum error counter

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fcs_cnt_r <= 16'h0000;
      cnt_hi_r  <= 8'h00;
    end
    else if (rd_lo)
    begin
      cnt_hi_r  <= fcs_cnt_r[15:8];
      fcs_cnt_r <= fcs_inc ? 16'h0001 : 16'h0000;
    end
    else if (fcs_inc && fcs_cnt_r != FCS_MAX)
      fcs_cnt_r <= fcs_cnt_r + 16'h0001;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sat_r <= 1'b0;
    else
      sat_r <= fcs_inc && !rd_lo && (fcs_cnt_r == FCS_MAX - 16'h0001);
  end

  assign checksum_count_saturated_req = sat_r;
  assign bus.reg_rdata                = rdata_r;
  assign bus.irq_pin                  = irq_r;
endmodule

// file: pmdl_hdlc_fifo_host_regs_properties.sv
// Purpose: Properties of the data link register bus and interrupt pin
// Assumes: One clock, asynchronous active-high reset
// Notes: Mask and control shadows track bus writes
`timescale 1ns/1ps
module pmdl_hdlc_fifo_host_regs_properties
  import pmdl_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Device bus
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_pin,
  input wire logic [7:0] irq_req
);
  logic [7:0] mask_r;
  logic [7:0] ctrl_r;
  logic       tx_act;
  logic       rx_act;
  ////////////////////////////////////////////////////////////
  assign tx_act = |(irq_req[2:0] & mask_r[2:0]);
  assign rx_act = (|(irq_req[7:3] & mask_r[7:3])) & ctrl_r[CTRL_RX_EN];
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) mask_r <= MASKS_RST;
    else if (reg_wr && reg_addr == ADDR_MASKS) mask_r <= reg_wdata;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) ctrl_r <= CTRL_RST;
    else if (reg_wr && reg_addr == ADDR_CTRL) ctrl_r <= reg_wdata;
  ////////////////////////////////////////////////////////////
  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_ONE_STROBE: assert property (!(reg_wr && reg_rd))
    else $error("read and write strobes together");
  AST_WR_PULSE: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");
  AST_RSVD_ZERO: assert property (reg_wr && reg_addr == ADDR_RSVD |-> reg_wdata == 8'h00)
    else $error("nonzero write to reserved slot");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_IRQ_LEVEL: assert property (irq_pin == ($past(tx_act || rx_act) ^ $past(ctrl_r[CTRL_IRQ_POL])))
    else $error("interrupt pin level wrong");
  AST_RX_GATE: assert property (!$past(ctrl_r[CTRL_RX_EN]) && !$past(tx_act) |-> irq_pin == $past(ctrl_r[CTRL_IRQ_POL]))
    else $error("rx interrupt while receive disabled");
  AST_CNT_PAIR: assert property (reg_rd && reg_addr == ADDR_FCS_LO |-> ##[1:20] (reg_rd && reg_addr == ADDR_CNT_HI))
    else $error("high byte read did not follow");
  AST_FILL_RANGE: assert property (reg_rd && reg_addr == ADDR_RX_FILL |=> reg_rdata <= 8'h80)
    else $error("fill level beyond capacity");
endmodule

// file: pmdl_host_end.sv
// Purpose: Host end: APB command registers driving the device register bus
// Assumes: Zero-wait APB answers; one command in flight at a time
// Notes: Commands written while busy are dropped
`timescale 1ns/1ps
module pmdl_host_end (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode leads
  input  wire logic        framing_format_select,
  input  wire logic        compat_select_lead,
  // Device bus
  pmdl_if.host             bus
);
  import pmdl_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_TAKE} host_state_t;

  host_state_t state_r;
  logic [2:0]  op_r;
  logic        step_r;
  logic [15:0] result_r;
  logic [5:0]  addr_r;
  logic [7:0]  wdata_r;
  logic        wr_r;
  logic        rd_r;
  logic        rx_hdlc_enable_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        apb_wr;
  logic        mapped;
  logic [5:0]  cmd_addr;
  logic [7:0]  cmd_data;
  logic [2:0]  cmd_op;
  logic        start;

  assign mapped   = (paddr == APB_CMD) || (paddr == APB_STATUS) || (paddr == APB_RESULT);
  assign apb_wr   = psel && penable && pready_r && pwrite && (paddr == APB_CMD);
  assign cmd_addr = pwdata[CMD_ADDR_LSB +: 6];
  assign cmd_data = pwdata[CMD_DATA_LSB +: 8];
  assign cmd_op   = pwdata[CMD_OP_LSB +: 3];
  assign start    = apb_wr && (state_r == H_IDLE) &&
                    (cmd_op == OP_WRITE || cmd_op == OP_READ ||
                     cmd_op == OP_READ16 || cmd_op == OP_FLUSH);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one access cycle, answer registered in the setup cycle

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          APB_STATUS: prdata_r <= {29'h0,
                                   !framing_format_select && rx_hdlc_enable_r &&
                                   !compat_select_lead,
                                   bus.irq_pin, state_r != H_IDLE};
          APB_RESULT: prdata_r <= {16'h0000, result_r};
          default:    prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r  <= H_IDLE;
      op_r     <= 3'h0;
      step_r   <= 1'b0;
      result_r <= 16'h0000;
      addr_r   <= 6'h00;
      wdata_r  <= 8'h00;
      wr_r     <= 1'b0;
      rd_r     <= 1'b0;
    end
    else
    begin
      case (state_r)
        H_IDLE:
        begin
          if (start)
          begin
            op_r    <= cmd_op;
            step_r  <= 1'b0;
            state_r <= H_WAIT;
            wr_r    <= (cmd_op == OP_WRITE);
            rd_r    <= (cmd_op != OP_WRITE);
            wdata_r <= (cmd_addr == ADDR_RSVD) ? 8'h00 : cmd_data;
            case (cmd_op)
              OP_READ16: addr_r <= ADDR_FCS_LO;
              OP_FLUSH:  addr_r <= ADDR_RX_FILL;
              default:   addr_r <= cmd_addr;
            endcase
          end
        end
        H_WAIT:
        begin
          wr_r    <= 1'b0;
          rd_r    <= 1'b0;
          state_r <= (op_r == OP_WRITE) ? H_IDLE : H_TAKE;
        end
        H_TAKE:
        begin
          state_r <= H_IDLE;
          case (op_r)
            OP_READ16:
            begin
              if (!step_r)
              begin
                result_r[7:0] <= bus.reg_rdata;
                addr_r        <= ADDR_CNT_HI;
                rd_r          <= 1'b1;
                step_r        <= 1'b1;
                state_r       <= H_WAIT;
              end
              else
                result_r[15:8] <= bus.reg_rdata;
            end
            OP_FLUSH:
            begin
              if (step_r || bus.reg_rdata != 8'h00)
              begin
                addr_r  <= step_r ? ADDR_RX_FILL : ADDR_RX_FIFO;
                rd_r    <= 1'b1;
                step_r  <= !step_r;
                state_r <= H_WAIT;
              end
              else
                result_r <= 16'h0000;
            end
            default: result_r <= {8'h00, bus.reg_rdata};
          endcase
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // Shadow of the receive enable, needed to judge the error count
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rx_hdlc_enable_r <= CTRL_RST[CTRL_RX_EN];
    else if (wr_r && addr_r == ADDR_CTRL)
      rx_hdlc_enable_r <= wdata_r[CTRL_RX_EN];
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign bus.reg_addr  = addr_r;
  assign bus.reg_wdata = wdata_r;
  assign bus.reg_wr    = wr_r;
  assign bus.reg_rd    = rd_r;
endmodule

// file: pmdl_if.sv
// Purpose: Parallel register bus between host controller and device
// Assumes: Both ends on one clock; strobes are one-cycle pulses
// Notes: Read data is valid from the edge after the read strobe
`timescale 1ns/1ps
interface pmdl_if;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       irq_pin;
  modport dev  (input reg_addr, input reg_wdata, input reg_wr, input reg_rd,
                output reg_rdata, output irq_pin);
  modport host (output reg_addr, output reg_wdata, output reg_wr, output reg_rd,
                input reg_rdata, input irq_pin);
endinterface

// file: pmdl_pkg.sv
// Purpose: Shared constants for the path data link register bus and its two ends
// Assumes: One 25 MHz clock, asynchronous active-high reset
// Notes: Byte register map on the device side, word map on the APB side
package pmdl_pkg;
  // Device register offsets
  localparam logic [5:0]  ADDR_MASKS    = 6'h35;
  localparam logic [5:0]  ADDR_RSVD     = 6'h36;
  localparam logic [5:0]  ADDR_TX_FIFO  = 6'h37;
  localparam logic [5:0]  ADDR_RX_FIFO  = 6'h38;
  localparam logic [5:0]  ADDR_RX_LEN   = 6'h39;
  localparam logic [5:0]  ADDR_RX_FILL  = 6'h3a;
  localparam logic [5:0]  ADDR_FCS_LO   = 6'h3b;
  localparam logic [5:0]  ADDR_CTRL     = 6'h3d;
  localparam logic [5:0]  ADDR_CNT_HI   = 6'h3e;
  // Field positions
  localparam int          MASK_TX_MSG   = 0;
  localparam int          MASK_TX_FIFO  = 1;
  localparam int          MASK_RX_LSB   = 3;
  localparam int          CTRL_RX_EN    = 4;
  localparam int          CTRL_IRQ_POL  = 6;
  // Reset values
  localparam logic [7:0]  MASKS_RST     = 8'h00;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  // Timing and sizes
  localparam logic [15:0] BIT_DIV       = 16'h0004;
  localparam int          FIFO_DEPTH    = 128;
  localparam logic [15:0] FCS_MAX       = 16'hffff;
  localparam logic [8:0]  LEN_SAT       = 9'h100;
  // APB map of the host controller
  localparam logic [11:0] APB_CMD       = 12'h000;
  localparam logic [11:0] APB_STATUS    = 12'h004;
  localparam logic [11:0] APB_RESULT    = 12'h008;
  localparam int          CMD_ADDR_LSB  = 0;
  localparam int          CMD_DATA_LSB  = 8;
  localparam int          CMD_OP_LSB    = 16;
  localparam logic [2:0]  OP_WRITE      = 3'h1;
  localparam logic [2:0]  OP_READ       = 3'h2;
  localparam logic [2:0]  OP_READ16     = 3'h3;
  localparam logic [2:0]  OP_FLUSH      = 3'h4;
endpackage

// file: tb_pmdl_hdlc_fifo_host_regs.sv
// Purpose: Self-checking bench for host end and device end joined
// Assumes: 25 MHz clock, APB master in the bench
// Notes: Results queued by the driver, compared by a watcher
`timescale 1ns/1ps
module tb_pmdl_hdlc_fifo_host_regs;
  import pmdl_pkg::*;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, fmt, compat, good, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  irq_req, b;
  logic [7:0]  bq [3];
  logic [3:0]  alarm;
  logic        tx_bit, tx_busy, rx_bit, rx_bit_valid, rx_frame_end, rx_fcs_bad, sat, res_stb;
  logic [15:0] res_val;
  logic [15:0] exp_q [$];
  int          err_count, num_checks, cyc, sat_n;
  pmdl_if u_pmdl_if ();
  pmdl_dev_end #(.DEPTH(FIFO_DEPTH)) u_pmdl_dev_end (.clk(clk), .sys_rst(sys_rst), .bus(u_pmdl_if),
    .irq_req(irq_req), .tx_bit(tx_bit), .tx_busy(tx_busy), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .rx_frame_end(rx_frame_end), .rx_frame_good(good),
    .rx_fcs_bad(rx_fcs_bad), .ds3_los(alarm[0]), .ds3_oof(alarm[1]), .ds3_ais(alarm[2]),
    .ds3_idle(alarm[3]), .checksum_count_saturated_req(sat));
  pmdl_host_end u_pmdl_host_end (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .framing_format_select(fmt), .compat_select_lead(compat), .bus(u_pmdl_if));
  pmdl_hdlc_fifo_host_regs_properties u_pmdl_hdlc_fifo_host_regs_properties (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(u_pmdl_if.reg_addr), .reg_wdata(u_pmdl_if.reg_wdata),
    .reg_wr(u_pmdl_if.reg_wr), .reg_rd(u_pmdl_if.reg_rd), .reg_rdata(u_pmdl_if.reg_rdata),
    .irq_pin(u_pmdl_if.irq_pin), .irq_req(irq_req));
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] result expected %h seen %h", exp, got);
    end
  endtask
  // Watcher: oldest note against each result
  always @(posedge clk) if (res_stb === 1'b1) check(res_val, exp_q.pop_front());
  always @(posedge clk) if (sat === 1'b1) sat_n++;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////
  // Pready sampled at the rising edge that completes the access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 50) err_count++;
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic note(input logic [15:0] exp, input logic [15:0] got);
    exp_q.push_back(exp);
    res_val <= got;
    res_stb <= 1;
    @(posedge clk);
    res_stb <= 0;
    // Gap so a following note never rewrites the strobe in this step
    @(posedge clk);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [5:0] a, input logic [7:0] d);
    apb(1, APB_CMD, {13'h0, op, d, 2'h0, a});
    q = 32'h1;
    for (int n = 0; n < 200 && q[0] !== 1'b0; n++) apb(0, APB_STATUS, 32'h0);
    if (q[0] !== 1'b0) err_count++;
  endtask
  task automatic rd(input logic [2:0] op, input logic [5:0] a, input logic [15:0] exp);
    cmd(op, a, 8'h00);
    apb(0, APB_RESULT, 32'h0);
    note(exp, q[15:0]);
  endtask
  task automatic send(input logic [7:0] v);
    @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      {rx_bit, rx_bit_valid} <= {v[i], 1'b1};
      @(posedge clk);
      rx_bit_valid <= 0;
      @(posedge clk);
    end
  endtask
  task automatic pulse_end();
    rx_frame_end <= 1;
    @(posedge clk);
    rx_frame_end <= 0;
    @(posedge clk);
  endtask
  task automatic txcap(input logic [7:0] v);
    logic [7:0] g;
    for (int n = 0; n < 400 && tx_busy !== 1'b1; n++) @(negedge clk);
    if (tx_busy !== 1'b1) err_count++;
    @(negedge clk);
    for (int k = 0; k < 8; k++)
    begin
      g[k] = tx_bit;
      repeat (4) @(negedge clk);
    end
    @(posedge clk);
    note({8'h0, v}, {8'h0, g});
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, fmt, compat} = {1'b1, 49'h0};
    {irq_req, alarm, rx_bit, rx_bit_valid, rx_frame_end, rx_fcs_bad, res_stb} = '0;
    res_val = 0;
    good = 1'b1;
    void'($urandom(32'h077454cf));
    repeat (12) @(posedge clk);
    sys_rst <= 0;
    cmd(OP_FLUSH, 6'h00, 8'h00);
    rd(OP_READ, ADDR_RX_FILL, 16'h0000);
    cmd(OP_WRITE, ADDR_CTRL, 8'h10);
    b = 8'($urandom);
    send(b);
    rd(OP_READ, ADDR_RX_FILL, 16'h0001);
    rd(OP_READ, ADDR_RX_FIFO, {8'h0, b});
    rd(OP_READ, ADDR_RX_FILL, 16'h0000);
    foreach (bq[i])
    begin
      bq[i] = 8'($urandom);
      send(bq[i]);
    end
    pulse_end();
    // Frame holds the first byte as well: no end event came between them
    rd(OP_READ, ADDR_RX_LEN, 16'h0004);
    rd(OP_READ, ADDR_RX_LEN, 16'h0000);
    pulse_end();
    rd(OP_READ, ADDR_RX_LEN, 16'h00ff);
    good <= 0;
    pulse_end();
    good <= 1;
    rd(OP_READ, ADDR_RX_LEN, 16'h0000);
    rd(OP_READ, ADDR_RX_FILL, 16'h0003);
    foreach (bq[i]) rd(OP_READ, ADDR_RX_FIFO, {8'h0, bq[i]});
    // Alarms each inhibit one error, then two clean errors
    for (int i = 0; i < 6; i++)
    begin
      alarm <= (i < 4) ? 4'h1 << i : 4'h0;
      rx_fcs_bad <= 1;
      @(posedge clk);
      {alarm, rx_fcs_bad} <= 5'h00;
      @(posedge clk);
    end
    rd(OP_READ16, ADDR_FCS_LO, 16'h0002);
    rd(OP_READ16, ADDR_FCS_LO, 16'h0000);
    apb(0, APB_STATUS, 32'h0);
    note(16'h1, {15'h0, q[2]});
    fmt <= 1;
    apb(0, APB_STATUS, 32'h0);
    note(16'h0, {15'h0, q[2]});
    {fmt, compat} <= 2'b01;
    apb(0, APB_STATUS, 32'h0);
    note(16'h0, {15'h0, q[2]});
    compat <= 0;
    apb(0, 12'h00c, 32'h0);
    note(16'h1, {15'h0, e});
    b = 8'($urandom);
    fork
      cmd(OP_WRITE, ADDR_TX_FIFO, b);
      txcap(b);
    join
    cmd(OP_WRITE, ADDR_RSVD, 8'ha5);
    // Masks, polarity and rx enable with random requests
    foreach (bq[i])
    begin
      cmd(OP_WRITE, ADDR_MASKS, 8'($urandom));
      cmd(OP_WRITE, ADDR_CTRL, {1'b0, i[0], 1'b0, ~i[1], 4'h0});
      repeat (30)
      begin
        @(posedge clk);
        irq_req <= 8'($urandom);
      end
    end
    // Saturation takes the full 16-bit range of errors
    cmd(OP_WRITE, ADDR_CTRL, 8'h10);
    rx_fcs_bad <= 1;
    repeat (65540) @(posedge clk);
    rx_fcs_bad <= 0;
    rd(OP_READ16, ADDR_FCS_LO, 16'hffff);
    note(16'h1, sat_n[15:0]);
    conclude();
  end
endmodule
